// ==== fcsd_bank.v ====
// fcsd_bank.v: read mode and operation flags of one flash bank.
// assumes one-cycle event pulses from the decoder, already checked
// for legality, and op_done pulses from the embedded algorithm.
`timescale 1ns/100ps
`default_nettype none
`include "fcsd_defs.vh"
module fcsd_bank (
  input  wire       clk,
  input  wire       arst_n,
  input  wire       ce,
  input  wire       sel,
  input  wire       ev_reset,
  input  wire       ev_asel,
  input  wire       ev_query,
  input  wire       ev_cfgrd,
  input  wire       ev_byp_on,
  input  wire       ev_byp_off,
  input  wire       ev_pgm,
  input  wire       ev_ers,
  input  wire       ev_susp,
  input  wire       ev_res,
  input  wire       op_done,
  input  wire       timeout,
  output reg  [2:0] mode_q,
  output reg        busy_q,
  output reg        susp_q,
  output reg        susp_ers_q,
  output reg        byp_q
);
  reg ers_q;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q     <= `FCSD_M_ARRAY;
      busy_q     <= 1'b0;
      susp_q     <= 1'b0;
      susp_ers_q <= 1'b0;
      byp_q      <= 1'b0;
      ers_q      <= 1'b0;
    end else if (ce) begin
      if (op_done && busy_q) begin
        busy_q <= 1'b0;
        mode_q <= `FCSD_M_ARRAY;
      end
      if (sel) begin
        // a running operation only yields to reset once it timed out
        if (ev_reset && (!busy_q || timeout)) begin
          mode_q <= `FCSD_M_ARRAY;
          busy_q <= 1'b0;
        end
        if (ev_asel && !busy_q)
          mode_q <= `FCSD_M_ASEL;
        if (ev_query && !busy_q)
          mode_q <= `FCSD_M_QUERY;
        if (ev_cfgrd && !busy_q)
          mode_q <= `FCSD_M_CFGRD;
        if (ev_byp_on)
          byp_q <= 1'b1;
        if (ev_byp_off) begin
          byp_q  <= 1'b0;
          mode_q <= `FCSD_M_ARRAY;
        end
        if (ev_pgm || ev_ers) begin
          busy_q <= 1'b1;
          ers_q  <= ev_ers;
          mode_q <= `FCSD_M_STATUS;
        end
        if (ev_susp) begin
          busy_q     <= 1'b0;
          susp_q     <= 1'b1;
          susp_ers_q <= ers_q;
          mode_q     <= `FCSD_M_ARRAY;
        end
        if (ev_res) begin
          susp_q <= 1'b0;
          busy_q <= 1'b1;
          ers_q  <= susp_ers_q;
          mode_q <= `FCSD_M_STATUS;
        end
      end
    end
  end
endmodule // fcsd_bank
`default_nettype wire

// ==== fcsd_decoder.v ====
// fcsd_decoder.v: command sequence decoder of a banked burst nor flash.
// assumes bus pins already synchronous to clk; the embedded algorithms,
// array, query rom and status logic sit outside and answer on ports.
// Functional notes
// - all command cycles are writes except reads
// - upper data byte ignored outside data cycles
// - address bits 14 to 20 ignored, bits 21 and up select the bank
// - array-read bank answers plain reads directly
// - reset leaves autoselect, query, timed-out status
// - lock verify reads 0000h or 0001h
// - bypass entry enables two-cycle program and erase
// - bypass chip, sector erase and query codes
// - bypass commands only after bypass entry
// - only bypass reset 90h 00h leaves bypass
// - write buffer load also allowed in bypass
// - suspend honoured only while bank busy
// - erase suspend permits reads, programs, autoselect
// - resume honoured only while bank suspended
// - buffer sequences up to 37 cycles
// - config low word must precede high word
// - address latches at first valid strobe edge
// - data latches at first strobe rising edge
// - read data changes on rising clock edges
`timescale 1ns/100ps
`default_nettype none
`include "fcsd_defs.vh"
module fcsd_decoder #(
  parameter AW       = 25,
  parameter BW       = 4,
  parameter NB       = 16,
  parameter WB_WORDS = 32,
  // identification words: arbitrary neutral values
  parameter [15:0] MFR_ID  = 16'h0001,
  parameter [15:0] DEV_ID1 = 16'h1234,
  parameter [15:0] DEV_ID2 = 16'h5678,
  parameter [15:0] DEV_ID3 = 16'h9abc,
  parameter [15:0] IND_BITS = 16'h0000
) (
  input  wire          clk,
  input  wire          arst_n,
  input  wire          ce,
  input  wire          chip_sel_n,
  input  wire          write_strobe_n,
  input  wire          out_en_n,
  input  wire          address_valid_strobe_n,
  input  wire [AW-1:0] addr_in,
  input  wire [15:0]   dq_in,
  output reg  [15:0]   dq_out_q,
  output reg           dq_oe_q,
  output reg  [AW-1:0] array_addr_q,
  input  wire [15:0]   array_rdata,
  input  wire [15:0]   query_rdata,
  input  wire [15:0]   status_rdata,
  input  wire          sector_locked,
  input  wire [NB-1:0] op_done,
  input  wire [NB-1:0] timeout_status_bit,
  output reg           op_start_q,
  output reg  [1:0]    op_kind_q,
  output reg  [AW-1:0] op_addr_q,
  output reg           pgm_we_q,
  output reg  [AW-1:0] pgm_addr_q,
  output reg  [15:0]   pgm_data_q,
  output wire [NB-1:0] bank_busy,
  output wire [NB-1:0] bank_susp,
  output wire [NB-1:0] bank_bypass,
  output reg  [15:0]   config_word_low_q,
  output reg  [15:0]   config_word_high_q,
  output reg           wb_aborted_q
);
  localparam [3:0] S_IDLE = 4'h0, S_U1 = 4'h1, S_U2 = 4'h2, S_PGM = 4'h3,
                   S_E1 = 4'h4, S_E2 = 4'h5, S_E3 = 4'h6, S_BP80 = 4'h7,
                   S_BP90 = 4'h8, S_WBWC = 4'h9, S_WBLD = 4'ha,
                   S_WBCF = 4'hb, S_CFG0 = 4'hc, S_CFG1 = 4'hd;

  reg  [3:0]    seq_q;
  reg  [AW-1:0] addr_lat_q;
  reg           addr_got_q;
  reg  [15:0]   data_lat_q;
  reg           wr_act_q;
  reg  [7:0]    wb_cnt_q;
  reg  [BW-1:0] wb_bank_q;
  reg  [15:0]   cfg_pend_q;
  reg  [BW-1:0] ev_bank_q;
  reg           ev_reset_q, ev_asel_q, ev_query_q, ev_cfgrd_q;
  reg           ev_byp_on_q, ev_byp_off_q, ev_pgm_q, ev_ers_q;
  reg           ev_susp_q, ev_res_q;
  wire [2*NB*1+NB-1:0] mode_v;
  wire [NB-1:0] susp_ers_v;

  // write cycle ends on the first rising strobe edge
  wire wr_low    = !chip_sel_n && !write_strobe_n;
  wire wr_commit = wr_act_q && !wr_low;
  wire rd_cyc    = !chip_sel_n && !out_en_n && write_strobe_n;
  wire [`FCSD_MATCH_W-1:0] ca = addr_lat_q[`FCSD_MATCH_W-1:0];
  wire [7:0]    cd = data_lat_q[7:0];
  wire [BW-1:0] cb = addr_lat_q[AW-1 -: BW];
  wire [7:0]    ix = addr_lat_q[7:0];
  wire          b_busy = bank_busy[cb];
  wire          b_susp = bank_susp[cb];
  wire          b_byp  = bank_bypass[cb];
  wire          b_sers = susp_ers_v[cb];
  wire [2:0]    b_mode = mode_v[3*cb +: 3];
  // erase suspend still lets a program in
  wire ok_pgm = !b_busy && (!b_susp || b_sers);
  wire ok_ers = !b_busy && !b_susp;
  wire wc_ok  = (cd <= (WB_WORDS[7:0] - 8'h01));

  genvar gi;
  generate
    for (gi = 0; gi < NB; gi = gi + 1) begin : g_bank
      localparam [BW-1:0] BANK_IX = gi;
      fcsd_bank u_bank (
        .clk        (clk),
        .arst_n     (arst_n),
        .ce         (ce),
        .sel        (ev_bank_q == BANK_IX),
        .ev_reset   (ev_reset_q),
        .ev_asel    (ev_asel_q),
        .ev_query   (ev_query_q),
        .ev_cfgrd   (ev_cfgrd_q),
        .ev_byp_on  (ev_byp_on_q),
        .ev_byp_off (ev_byp_off_q),
        .ev_pgm     (ev_pgm_q),
        .ev_ers     (ev_ers_q),
        .ev_susp    (ev_susp_q),
        .ev_res     (ev_res_q),
        .op_done    (op_done[gi]),
        .timeout    (timeout_status_bit[gi]),
        .mode_q     (mode_v[3*gi +: 3]),
        .busy_q     (bank_busy[gi]),
        .susp_q     (bank_susp[gi]),
        .susp_ers_q (susp_ers_v[gi]),
        .byp_q      (bank_bypass[gi])
      );
    end
  endgenerate

  // address and data capture on the pins
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_lat_q <= {AW{1'b0}};
      addr_got_q <= 1'b0;
      data_lat_q <= 16'h0000;
      wr_act_q   <= 1'b0;
    end else if (ce) begin
      // the clock edge while the strobe is low always precedes its
      // rising edge here, so that edge is the one that latches
      if (!address_valid_strobe_n && !addr_got_q) begin
        addr_lat_q <= addr_in;
        addr_got_q <= 1'b1;
      end else if (address_valid_strobe_n)
        addr_got_q <= 1'b0;
      wr_act_q <= wr_low;
      if (wr_low)
        data_lat_q <= dq_in;
    end
  end

  // registered read path
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dq_out_q     <= 16'h0000;
      dq_oe_q      <= 1'b0;
      array_addr_q <= {AW{1'b0}};
    end else if (ce) begin
      dq_oe_q      <= rd_cyc;
      array_addr_q <= addr_lat_q;
      if (rd_cyc) begin
        case (b_mode)
          `FCSD_M_ARRAY:  dq_out_q <= array_rdata;
          `FCSD_M_QUERY:  dq_out_q <= query_rdata;
          `FCSD_M_STATUS: dq_out_q <= status_rdata;
          `FCSD_M_CFGRD:
            dq_out_q <= ix[0] ? config_word_high_q : config_word_low_q;
          `FCSD_M_ASEL: begin
            case (ix)
              `FCSD_AS_MFR:  dq_out_q <= MFR_ID;
              `FCSD_AS_DEV1: dq_out_q <= DEV_ID1;
              `FCSD_AS_DEV2: dq_out_q <= DEV_ID2;
              `FCSD_AS_DEV3: dq_out_q <= DEV_ID3;
              `FCSD_AS_IND:  dq_out_q <= IND_BITS;
              `FCSD_AS_LOCK:
                dq_out_q <= sector_locked ? `FCSD_LOCKED
                                          : `FCSD_UNLOCKED;
              default:       dq_out_q <= 16'h0000;
            endcase
          end
          default: dq_out_q <= array_rdata;
        endcase
      end
    end
  end

  // command sequencer, advanced once per committed write cycle
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seq_q              <= S_IDLE;
      wb_cnt_q           <= 8'h00;
      wb_bank_q          <= {BW{1'b0}};
      cfg_pend_q         <= `FCSD_CFG_RST;
      config_word_low_q  <= `FCSD_CFG_RST;
      config_word_high_q <= `FCSD_CFG_RST;
      wb_aborted_q       <= 1'b0;
      op_start_q         <= 1'b0;
      op_kind_q          <= `FCSD_OP_WORD;
      op_addr_q          <= {AW{1'b0}};
      pgm_we_q           <= 1'b0;
      pgm_addr_q         <= {AW{1'b0}};
      pgm_data_q         <= 16'h0000;
      ev_bank_q          <= {BW{1'b0}};
      ev_reset_q         <= 1'b0;
      ev_asel_q          <= 1'b0;
      ev_query_q         <= 1'b0;
      ev_cfgrd_q         <= 1'b0;
      ev_byp_on_q        <= 1'b0;
      ev_byp_off_q       <= 1'b0;
      ev_pgm_q           <= 1'b0;
      ev_ers_q           <= 1'b0;
      ev_susp_q          <= 1'b0;
      ev_res_q           <= 1'b0;
    end else if (ce) begin
      op_start_q   <= 1'b0;
      pgm_we_q     <= 1'b0;
      ev_reset_q   <= 1'b0;
      ev_asel_q    <= 1'b0;
      ev_query_q   <= 1'b0;
      ev_cfgrd_q   <= 1'b0;
      ev_byp_on_q  <= 1'b0;
      ev_byp_off_q <= 1'b0;
      ev_pgm_q     <= 1'b0;
      ev_ers_q     <= 1'b0;
      ev_susp_q    <= 1'b0;
      ev_res_q     <= 1'b0;
      if (wr_commit) begin
        ev_bank_q <= cb;
        // malformed input falls back to idle; host must then reset
        seq_q <= S_IDLE;
        case (seq_q)
          S_IDLE: begin
            if (ca == `FCSD_A_UNLK1 && cd == `FCSD_C_AA)
              seq_q <= S_U1;
            else if (b_byp && cd == `FCSD_C_PGM)
              seq_q <= S_PGM;
            else if (b_byp && cd == `FCSD_C_ERASE)
              seq_q <= S_BP80;
            else if (b_byp && cd == `FCSD_C_ASEL)
              seq_q <= S_BP90;
            else if (b_byp && cd == `FCSD_C_QUERY)
              ev_query_q <= 1'b1;
            else if (ca == `FCSD_A_QUERY && cd == `FCSD_C_QUERY)
              ev_query_q <= 1'b1;
            else if (cd == `FCSD_C_SUSP)
              ev_susp_q <= b_busy;
            else if (cd == `FCSD_C_SECT)
              ev_res_q <= b_susp;
            else if (cd == `FCSD_C_RESET)
              ev_reset_q <= 1'b1;
          end
          S_U1:
            if (ca == `FCSD_A_UNLK2 && cd == `FCSD_C_55)
              seq_q <= S_U2;
          S_U2: begin
            if (cd == `FCSD_C_WBLOAD) begin
              seq_q     <= S_WBWC;
              wb_bank_q <= cb;
              op_addr_q <= addr_lat_q;
            end else if (ca == `FCSD_A_UNLK1) begin
              case (cd)
                `FCSD_C_ASEL:   ev_asel_q <= 1'b1;
                `FCSD_C_PGM:    seq_q <= S_PGM;
                `FCSD_C_ERASE:  seq_q <= S_E1;
                `FCSD_C_CFGSET: seq_q <= S_CFG0;
                `FCSD_C_CFGRD:  ev_cfgrd_q <= 1'b1;
                `FCSD_C_BYPASS: ev_byp_on_q <= 1'b1;
                `FCSD_C_RESET: begin
                  wb_aborted_q <= 1'b0;
                  ev_reset_q   <= 1'b1;
                end
                default: seq_q <= S_IDLE;
              endcase
            end
          end
          S_PGM:
            if (ok_pgm) begin
              op_start_q <= 1'b1;
              op_kind_q  <= `FCSD_OP_WORD;
              op_addr_q  <= addr_lat_q;
              pgm_we_q   <= 1'b1;
              pgm_addr_q <= addr_lat_q;
              pgm_data_q <= data_lat_q;
              ev_pgm_q   <= 1'b1;
            end
          S_E1:
            if (ca == `FCSD_A_UNLK1 && cd == `FCSD_C_AA)
              seq_q <= S_E2;
          S_E2:
            if (ca == `FCSD_A_UNLK2 && cd == `FCSD_C_55)
              seq_q <= S_E3;
          S_E3, S_BP80: begin
            // full sequence needs 555h for chip erase, bypass does not
            if (cd == `FCSD_C_CHIP && ok_ers &&
                (seq_q == S_BP80 || ca == `FCSD_A_UNLK1)) begin
              op_start_q <= 1'b1;
              op_kind_q  <= `FCSD_OP_CHIP;
              op_addr_q  <= addr_lat_q;
              ev_ers_q   <= 1'b1;
            end else if (cd == `FCSD_C_SECT && ok_ers) begin
              op_start_q <= 1'b1;
              op_kind_q  <= `FCSD_OP_SECT;
              op_addr_q  <= addr_lat_q;
              ev_ers_q   <= 1'b1;
            end
          end
          S_BP90:
            if (cd == `FCSD_C_BYPRST)
              ev_byp_off_q <= 1'b1;
          S_WBWC:
            if (wc_ok) begin
              wb_cnt_q <= cd;
              seq_q    <= S_WBLD;
            end else
              wb_aborted_q <= 1'b1;
          S_WBLD: begin
            // the buffer base address was taken from the 25h write cycle
            pgm_we_q   <= 1'b1;
            pgm_addr_q <= addr_lat_q;
            pgm_data_q <= data_lat_q;
            if (cb != wb_bank_q)
              wb_aborted_q <= 1'b1;
            else if (wb_cnt_q == 8'h00)
              seq_q <= S_WBCF;
            else begin
              wb_cnt_q <= wb_cnt_q - 8'h01;
              seq_q    <= S_WBLD;
            end
          end
          S_WBCF:
            if (cd == `FCSD_C_WBCONF && ok_pgm) begin
              op_start_q <= 1'b1;
              op_kind_q  <= `FCSD_OP_BUF;
              ev_pgm_q   <= 1'b1;
            end else
              wb_aborted_q <= 1'b1;
          S_CFG0:
            if (ix == `FCSD_CFG_LO_IX) begin
              cfg_pend_q <= data_lat_q;
              seq_q      <= S_CFG1;
            end
          S_CFG1:
            // out of order writes leave both words untouched
            if (ix == `FCSD_CFG_HI_IX) begin
              config_word_low_q  <= cfg_pend_q;
              config_word_high_q <= data_lat_q;
            end
          default: seq_q <= S_IDLE;
        endcase
      end
    end
  end
endmodule // fcsd_decoder
`default_nettype wire

// ==== fcsd_decoder_chk.sv ====
// fcsd_decoder_chk.sv: port-level checks of the command decoder.
// assumes bind into fcsd_decoder; one clock, async active-low reset.
`timescale 1ns/100ps
`default_nettype none
module fcsd_decoder_chk #(
  parameter AW = 25,
  parameter NB = 16
) (
  input wire logic          clk,
  input wire logic          arst_n,
  input wire logic          chip_sel_n,
  input wire logic          write_strobe_n,
  input wire logic          out_en_n,
  input wire logic [AW-1:0] addr_in,
  input wire logic [15:0]   dq_in,
  input wire logic          dq_oe_q,
  input wire logic          op_start_q,
  input wire logic          pgm_we_q,
  input wire logic [AW-1:0] pgm_addr_q,
  input wire logic [15:0]   pgm_data_q,
  input wire logic [NB-1:0] bank_busy,
  input wire logic [NB-1:0] bank_susp,
  input wire logic [15:0]   config_word_high_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  we_pulse_a: assert property (pgm_we_q |=> !pgm_we_q)
    else $error("program strobe longer than one cycle");
  we_cause_a: assert property (pgm_we_q |->
    $past(!chip_sel_n && !write_strobe_n, 2) && $past(write_strobe_n))
    else $error("program strobe without a finished write");
  data_cap_a: assert property (pgm_we_q |->
    pgm_data_q == $past(dq_in, 2))
    else $error("program data not the written word");
  addr_cap_a: assert property (pgm_we_q |->
    pgm_addr_q == $past(addr_in, 2))
    else $error("program address not the latched one");
  start_busy_a: assert property (op_start_q |=>
    !op_start_q && bank_busy != '0)
    else $error("operation start without a busy bank");
  busy_cause_a: assert property (
    (bank_busy & ~$past(bank_busy) & ~$past(bank_susp)) != '0 |->
    $past(op_start_q || pgm_we_q))
    else $error("bank went busy without a start");
  susp_cause_a: assert property (
    (bank_susp & ~$past(bank_susp) & ~$past(bank_busy)) == '0)
    else $error("idle bank suspended");
  resume_busy_a: assert property (
    ($past(bank_susp) & ~bank_susp & ~bank_busy) == '0)
    else $error("resume left the bank idle");
  oe_cause_a: assert property (dq_oe_q |->
    $past(!chip_sel_n && !out_en_n))
    else $error("data driven without a read cycle");
  cfg_write_a: assert property ($changed(config_word_high_q) |->
    $past(!chip_sel_n && !write_strobe_n, 2))
    else $error("config word changed without a write");
endmodule // fcsd_decoder_chk
`default_nettype wire

// ==== fcsd_decoder_test.sv ====
// fcsd_decoder_test.sv: self-checking bench of the command decoder.
// assumes fcsd_host drives the bus; bench plays array and algorithm.
`timescale 1ns/100ps
`default_nettype none
module fcsd_decoder_test;
  localparam AW = 25;
  localparam NB = 16;
  logic          clk, arst_n, chip_sel_n, write_strobe_n, out_en_n;
  logic          address_valid_strobe_n, sector_locked, dq_oe_q;
  logic          op_start_q, pgm_we_q, wb_aborted_q, oe_q = 1'b0;
  logic [AW-1:0] addr_in, array_addr_q, op_addr_q, pgm_addr_q, sa;
  logic [15:0]   dq_in, dq_out_q, array_rdata, pgm_data_q, lo, hi;
  logic [15:0]   config_word_low_q, config_word_high_q;
  logic [1:0]    op_kind_q;
  logic [NB-1:0] op_done, bank_busy, bank_susp, bank_bypass, tmo;
  logic [3:0]    b;
  logic [42:0]   exp_q[$];
  int            fails, check_count, n;
  fcsd_decoder dut (.clk, .arst_n, .ce(1'b1), .chip_sel_n, .write_strobe_n,
    .out_en_n, .address_valid_strobe_n, .addr_in, .dq_in, .dq_out_q,
    .dq_oe_q, .array_addr_q, .array_rdata, .query_rdata(~array_rdata),
    .status_rdata(array_rdata ^ 16'h00ff), .sector_locked, .op_done,
    .timeout_status_bit(tmo), .op_start_q, .op_kind_q, .op_addr_q,
    .pgm_we_q, .pgm_addr_q, .pgm_data_q, .bank_busy, .bank_susp,
    .bank_bypass, .config_word_low_q, .config_word_high_q, .wb_aborted_q);
  fcsd_host #(.AW(AW)) h (.clk, .chip_sel_n, .write_strobe_n, .out_en_n,
    .address_valid_strobe_n, .addr_in, .dq_in);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string what, input logic [42:0] seen, want);
    check_count++;
    if (seen !== want) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // junk in bits 20:14 must not disturb matching
  function automatic logic [AW-1:0] ad(input logic [13:0] a);
    ad = {b, 7'($urandom), a};
  endfunction
  task automatic c(input logic [13:0] a, input logic [7:0] cmd);
    h.wr(ad(a), {8'($urandom), cmd});
  endtask
  task automatic unl();
    c(14'h0555, 8'haa);
    c(14'h02aa, 8'h55);
  endtask
  task automatic op(input logic [13:0] a, input logic [7:0] cmd,
                    input logic [1:0] k);
    logic [AW-1:0] x;
    x = ad(a);
    exp_q.push_back({2'h1, x, 14'h0, k});
    h.wr(x, {8'($urandom), cmd});
  endtask
  task automatic pg();
    logic [AW-1:0] x;
    logic [15:0]   d;
    x = ad(14'($urandom));
    d = 16'($urandom);
    exp_q.push_back({2'h0, x, d});
    h.wr(x, d);
  endtask
  task automatic rdx(input logic [13:0] a, input logic [15:0] want);
    exp_q.push_back({2'h2, 25'h0, want});
    h.rd(ad(a));
  endtask
  // embedded algorithm finishing in bank b
  task automatic done();
    @(posedge clk) #1;
    op_done[b] = 1'b1;
    @(posedge clk) #1;
    op_done = '0;
    @(posedge clk);
  endtask
  task automatic fl(input logic [2:0] w);
    #2;
    chk("flags", 43'({bank_busy[b], bank_susp[b], bank_bypass[b]}),
        43'(w));
  endtask
  // results are compared in the order the stimulus noted them
  always @(posedge clk) begin
    #2;
    if (pgm_we_q | (op_start_q & (op_kind_q != 2'h0)) |
        (dq_oe_q & !oe_q)) begin
      if (exp_q.size() == 0)
        chk("unexpected result", 43'h1, 43'h0);
      else
        chk("result", pgm_we_q ? {2'h0, pgm_addr_q, pgm_data_q} :
          op_start_q ? {2'h1, op_addr_q, 14'h0, op_kind_q} :
          {2'h2, 25'h0, dq_out_q}, exp_q.pop_front());
    end
    oe_q = dq_oe_q;
  end
  initial begin
    arst_n = 1'b0;
    sector_locked = 1'b0;
    array_rdata = 16'h0000;
    op_done = '0;
    tmo = '0;
    void'($urandom(32'h239d));
    b = 4'($urandom);
    repeat (16) @(posedge clk);
    #1 arst_n = 1'b1;
    chk("reset", 43'({config_word_low_q, config_word_high_q,
        wb_aborted_q}), 43'h0);
    array_rdata = 16'($urandom);
    rdx(14'($urandom), array_rdata);
    unl();
    c(14'h0555, 8'ha0);
    pg();
    fl(3'b100);
    // status shown while busy; reset ignored until timed out
    rdx(14'($urandom), array_rdata ^ 16'h00ff);
    c(14'($urandom), 8'hf0);
    fl(3'b100);
    @(posedge clk) #1 tmo[b] = 1'b1;
    c(14'($urandom), 8'hf0);
    fl(3'b000);
    @(posedge clk) #1 tmo = '0;
    done();
    c(14'($urandom), 8'hb0);
    c(14'($urandom), 8'h30);
    fl(3'b000);
    $display("test program done");
    for (int i = 0; i < 2; i++) begin
      unl();
      c(14'h0555, 8'h80);
      unl();
      op(i ? 14'($urandom) : 14'h0555, i ? 8'h30 : 8'h10, i ? 2'h3 : 2'h2);
      fl(3'b100);
      c(14'($urandom), 8'hb0);
      #2 chk("suspend", 43'(bank_susp[b]), 43'h1);
      rdx(14'($urandom), array_rdata);
      c(14'($urandom), 8'h30);
      fl(3'b100);
      done();
    end
    $display("test erase done");
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) #1 sector_locked = 1'(i);
      unl();
      c(14'h0555, 8'h90);
      rdx(14'h0002, 16'(i));
      c(14'($urandom), 8'hf0);
      rdx(14'($urandom), array_rdata);
    end
    $display("test autoselect done");
    c(14'($urandom), 8'ha0);
    h.wr(ad(14'($urandom)), 16'h0000);
    c(14'($urandom), 8'hf0);
    unl();
    c(14'h0555, 8'h20);
    fl(3'b001);
    c(14'($urandom), 8'ha0);
    pg();
    done();
    for (int i = 0; i < 2; i++) begin
      c(14'($urandom), 8'h80);
      op(14'($urandom), i ? 8'h30 : 8'h10, i ? 2'h3 : 2'h2);
      done();
    end
    // buffer load inside bypass, lowest address first
    unl();
    sa = ad(14'h0100);
    h.wr(sa, 16'h0025);
    h.wr(sa, 16'h0001);
    for (int i = 0; i < 2; i++) begin
      exp_q.push_back({2'h0, sa + 25'(i), array_rdata ^ 16'(i)});
      h.wr(sa + 25'(i), array_rdata ^ 16'(i));
    end
    exp_q.push_back({2'h1, sa, 14'h0, 2'h1});
    h.wr(sa, 16'h0029);
    done();
    fl(3'b001);
    c(14'($urandom), 8'h90);
    c(14'($urandom), 8'h00);
    fl(3'b000);
    $display("test bypass done");
    unl();
    c(14'h0555, 8'hd0);
    lo = 16'($urandom);
    hi = 16'($urandom);
    h.wr(ad(14'h0000), lo);
    h.wr(ad(14'h0001), hi);
    #2 chk("config", 43'({config_word_high_q, config_word_low_q}),
        43'({hi, lo}));
    unl();
    c(14'h0555, 8'hd0);
    h.wr(ad(14'h0001), ~hi);
    #2 chk("config order",
        43'({config_word_high_q, config_word_low_q}), 43'({hi, lo}));
    c(14'($urandom), 8'hf0);
    unl();
    c(14'h0555, 8'hc6);
    rdx(14'h0001, hi);
    c(14'($urandom), 8'hf0);
    c(14'h0055, 8'h98);
    rdx(14'($urandom), ~array_rdata);
    c(14'($urandom), 8'hf0);
    $display("test config done");
    // word count 40 is beyond what the buffer holds
    unl();
    sa = ad(14'($urandom));
    h.wr(sa, 16'h0025);
    h.wr(sa, 16'd40);
    #2 chk("abort", 43'(wb_aborted_q), 43'h1);
    unl();
    c(14'h0555, 8'hf0);
    #2 chk("abort clear", 43'(wb_aborted_q), 43'h0);
    $display("test buffer abort done");
    for (n = 0; n < 20 && exp_q.size() != 0; n++)
      @(posedge clk);
    if (exp_q.size() != 0)
      fails++;
    close_out();
  end
endmodule // fcsd_decoder_test
bind fcsd_decoder fcsd_decoder_chk #(.AW(AW), .NB(NB)) u_chk (
  .clk, .arst_n, .chip_sel_n, .write_strobe_n, .out_en_n, .addr_in,
  .dq_in, .dq_oe_q, .op_start_q, .pgm_we_q, .pgm_addr_q, .pgm_data_q,
  .bank_busy, .bank_susp, .config_word_high_q);
`default_nettype wire

// ==== fcsd_defs.vh ====
// fcsd_defs.vh: command codes, match addresses, modes and reset values
// of the flash command sequence decoder.
// assumes inclusion by fcsd_decoder.v and fcsd_bank.v only.
`ifndef FCSD_DEFS_VH
`define FCSD_DEFS_VH
`define FCSD_MATCH_W    14
`define FCSD_A_UNLK1    14'h0555
`define FCSD_A_UNLK2    14'h02aa
`define FCSD_A_QUERY    14'h0055
`define FCSD_C_AA       8'haa
`define FCSD_C_55       8'h55
`define FCSD_C_RESET    8'hf0
`define FCSD_C_ASEL     8'h90
`define FCSD_C_PGM      8'ha0
`define FCSD_C_WBLOAD   8'h25
`define FCSD_C_WBCONF   8'h29
`define FCSD_C_ERASE    8'h80
`define FCSD_C_CHIP     8'h10
`define FCSD_C_SECT     8'h30
`define FCSD_C_SUSP     8'hb0
`define FCSD_C_CFGSET   8'hd0
`define FCSD_C_CFGRD    8'hc6
`define FCSD_C_QUERY    8'h98
`define FCSD_C_BYPASS   8'h20
`define FCSD_C_BYPRST   8'h00
`define FCSD_AS_MFR     8'h00
`define FCSD_AS_DEV1    8'h01
`define FCSD_AS_LOCK    8'h02
`define FCSD_AS_IND     8'h03
`define FCSD_AS_DEV2    8'h0e
`define FCSD_AS_DEV3    8'h0f
`define FCSD_CFG_LO_IX  8'h00
`define FCSD_CFG_HI_IX  8'h01
`define FCSD_LOCKED     16'h0001
`define FCSD_UNLOCKED   16'h0000
`define FCSD_CFG_RST    16'h0000
`define FCSD_M_ARRAY    3'h0
`define FCSD_M_ASEL     3'h1
`define FCSD_M_QUERY    3'h2
`define FCSD_M_STATUS   3'h3
`define FCSD_M_CFGRD    3'h4
`define FCSD_OP_WORD    2'h0
`define FCSD_OP_BUF     2'h1
`define FCSD_OP_CHIP    2'h2
`define FCSD_OP_SECT    2'h3
`endif

// ==== fcsd_host.sv ====
// fcsd_host.sv: host memory controller model driving the flash bus.
// assumes the bench calls wr and rd one at a time, clocked by clk.
`timescale 1ns/100ps
`default_nettype none
module fcsd_host #(
  parameter AW = 25
) (
  input  wire logic          clk,
  output var  logic          chip_sel_n,
  output var  logic          write_strobe_n,
  output var  logic          out_en_n,
  output var  logic          address_valid_strobe_n,
  output var  logic [AW-1:0] addr_in,
  output var  logic [15:0]   dq_in
);
  initial begin
    chip_sel_n = 1'b1;
    write_strobe_n = 1'b1;
    out_en_n = 1'b1;
    address_valid_strobe_n = 1'b1;
    addr_in = '0;
    dq_in = '0;
  end
  // command or data write, latched on one edge
  task automatic wr(input logic [AW-1:0] a, input logic [15:0] d);
    @(posedge clk) #1;
    address_valid_strobe_n = 1'b0;
    chip_sel_n = 1'b0;
    write_strobe_n = 1'b0;
    addr_in = a;
    dq_in = d;
    @(posedge clk) #1;
    address_valid_strobe_n = 1'b1;
    chip_sel_n = 1'b1;
    write_strobe_n = 1'b1;
    // released bus shows the inverse so stale values never match
    addr_in = ~a;
    dq_in = ~d;
    repeat (2) @(posedge clk);
  endtask
  // plain read: address first, then output enable for two edges
  task automatic rd(input logic [AW-1:0] a);
    @(posedge clk) #1;
    address_valid_strobe_n = 1'b0;
    addr_in = a;
    @(posedge clk) #1;
    address_valid_strobe_n = 1'b1;
    addr_in = ~a;
    chip_sel_n = 1'b0;
    out_en_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chip_sel_n = 1'b1;
    out_en_n = 1'b1;
    @(posedge clk);
  endtask
endmodule // fcsd_host
`default_nettype wire
